// >>> core/imma_baud.sv
`timescale 1ns/1ps
`default_nettype none
module imma_baud (
	input  wire logic clock,
	input  wire logic rst,
	imma_baud_if.gen  bus
);
	import imma_pkg::*;

	logic [BAUD_W-1:0] count;

	// Rollover when a further double step would pass zero.
	assign bus.tick = bus.run && !bus.restart && !bus.hold
		&& (count < BAUD_STEP);

	// The counter steps by two each cycle, freezes while held and
	// reloads from the reload field when told the line went high.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= BAUD_RST;
		end else if (!bus.run || bus.restart) begin
			count <= bus.reload;
		end else if (bus.hold) begin
			count <= count;
		end else if (count < BAUD_STEP) begin
			count <= bus.reload;
		end else begin
			count <= count - BAUD_STEP;
		end
	end
endmodule : imma_baud
`default_nettype wire

// >>> core/imma_baud_if.sv
`timescale 1ns/1ps
`default_nettype none
// Control and timing handshake between the sequencer and the baud counter.
interface imma_baud_if;
	logic                         run;
	logic                         hold;
	logic                         restart;
	logic [imma_pkg::BAUD_W-1:0]  reload;
	logic                         tick;

	modport ctrl (output run, output hold, output restart, output reload,
		input tick);
	modport gen  (input run, input hold, input restart, input reload,
		output tick);
endinterface : imma_baud_if
`default_nettype wire

// >>> core/imma_master.sv
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - One-hot sequence bits plus transmit status bit.
// - Codes for restart, stop, receive, acknowledge.
// - Interrupt on completion of every master event.
// - Clock sync and arbitration always on.
// - Released clock suspends baud counter until high.
// - Clock seen high reloads baud counter.
// - Clock high lasts a full baud interval.
// - Counter steps twice per cycle; rollover toggles clock.
// - Clock sampled each cycle; low holds rollover.
// - Released data seen low: collision, interrupt, idle.
// - Arbitration checked in every driven sequence.
// - Byte collision halts, clears buffer flag, releases.
// - Sequence collision aborts, clears bit, releases.
// - Restart against another talker loses arbitration.
// - Start sets start flag, stop sets stop.
module imma_master (
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [imma_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	output logic                            irq,
	input  wire logic                       scl_i,
	input  wire logic                       sda_i,
	output logic                            scl_o,
	output logic                            scl_oe,
	output logic                            sda_o,
	output logic                            sda_oe
);
	import imma_pkg::*;

	imma_state_t       state;
	logic [1:0]        step;
	logic [3:0]        bitn;
	logic [7:0]        shreg;
	logic [7:0]        rxbyte;
	logic              ackdt;
	logic              ack_rx;
	logic              transmit_buffer_full;
	logic              arbitration_lost_flag;
	logic              start_seen;
	logic              stop_seen;
	logic              park_low;
	logic              high_seen;
	logic [1:0]        sda_age;
	logic [1:0]        irq_stat;
	logic [1:0]        irq_mask;
	logic [BAUD_W-1:0] baud_reload;
	logic [1:0]        pins_s;
	logic              scl_s;
	logic              sda_s;
	logic              scl_d;
	logic              sda_d;
	logic              want_scl;
	logic              want_sda;
	logic              chk;
	logic              last;
	logic              tick;
	logic              coll;
	logic              done;
	logic              wr;
	logic              ctrl_wr;
	logic              tx_wr;
	logic [31:0]       wm;
	logic [31:0]       rdata;

	// Byte enables widened to a bit mask.
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	// Sequence bits shown to software are decoded from the state.
	function automatic logic [4:0] seq_bits(input imma_state_t s);
		unique case (s)
			ST_START:   seq_bits = SEQ_START;
			ST_RESTART: seq_bits = SEQ_RESTART;
			ST_STOP:    seq_bits = SEQ_STOP;
			ST_RECV:    seq_bits = SEQ_RECV;
			ST_ACK:     seq_bits = SEQ_ACK;
			default:    seq_bits = 5'h00;
		endcase
	endfunction : seq_bits

	// The bus wires come from another domain and are synchronised first.
	imma_sync #(.W(2)) u_sync (
		.clock (clock),
		.rst   (rst),
		.d     ({scl_i, sda_i}),
		.q     (pins_s)
	);
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	imma_baud_if bif ();
	imma_baud u_baud (
		.clock (clock),
		.rst   (rst),
		.bus   (bif.gen)
	);

	// The counter runs only in a sequence and waits for a released
	// clock to be seen high, so a stretching slave or a slower master
	// lengthens the low time but never shortens the high time.
	assign bif.run     = (state != ST_IDLE);
	assign bif.hold    = bif.run && !scl_oe && !high_seen;
	assign bif.restart = bif.hold && scl_s;
	assign bif.reload  = baud_reload;
	assign tick        = bif.tick;

	// Register bus decode; a request acts on its first edge.
	assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign wm      = lane_mask(wb_sel_i);
	assign ctrl_wr = wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0];
	assign tx_wr   = wr && (wb_adr_i == OFS_TXD) && wb_sel_i[0];

	// Line drive per state and step, with the arbitration window.
	always_comb begin
		want_scl = 1'b0;
		want_sda = 1'b0;
		chk      = 1'b0;
		last     = 1'b0;
		unique case (state)
			ST_IDLE: begin
				want_scl = park_low;
			end
			ST_START: begin
				want_sda = (step != 2'h0);
				want_scl = (step == 2'h2);
				chk      = (step == 2'h0);
				last     = (step == 2'h2);
			end
			ST_RESTART: begin
				want_scl = (step == 2'h0) || (step == 2'h3);
				want_sda = (step[1] == 1'b1);
				chk      = (step == 2'h1);
				last     = (step == 2'h3);
			end
			ST_STOP: begin
				want_scl = (step == 2'h0);
				want_sda = (step != 2'h2);
				chk      = (step == 2'h2);
				last     = (step == 2'h2);
			end
			ST_ACK: begin
				want_scl = (step == 2'h0);
				want_sda = !ackdt;
				chk      = (step == 2'h1) && ackdt;
				last     = (step == 2'h1);
			end
			ST_XMIT: begin
				want_scl = (step == 2'h0);
				want_sda = (bitn != XMIT_LAST) && !shreg[7];
				chk      = (step == 2'h1) && (bitn != XMIT_LAST)
					&& shreg[7];
				last     = (step == 2'h1) && (bitn == XMIT_LAST);
			end
			ST_RECV: begin
				want_scl = (step == 2'h0);
				last     = (step == 2'h1) && (bitn == RECV_LAST);
			end
		endcase
	end

	// A collision needs our data released long enough for the synchroniser
	// to show it, with the clock seen high; else our own edge would trip it.
	assign coll = chk && high_seen && !sda_oe && (sda_age == SDA_SETTLE)
		&& !sda_s;
	assign done = tick && last && !coll;

	// Sequencer; sequences start only from idle, so events never queue.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			step  <= 2'h0;
			bitn  <= 4'h0;
		end else if (coll) begin
			state <= ST_IDLE;
		end else if (state == ST_IDLE) begin
			step <= 2'h0;
			bitn <= 4'h0;
			if (tx_wr) begin
				state <= ST_XMIT;
			end else if (ctrl_wr) begin
				unique case (wb_dat_i[4:0])
					SEQ_START:   state <= ST_START;
					SEQ_RESTART: state <= ST_RESTART;
					SEQ_STOP:    state <= ST_STOP;
					SEQ_RECV:    state <= ST_RECV;
					SEQ_ACK:     state <= ST_ACK;
					default:     state <= ST_IDLE;
				endcase
			end
		end else if (tick) begin
			if (last) begin
				state <= ST_IDLE;
			end else if ((state == ST_XMIT || state == ST_RECV)
					&& step == 2'h1) begin
				step <= 2'h0;
				bitn <= bitn + 4'h1;
			end else begin
				step <= step + 2'h1;
			end
		end
	end

	// Shift register serves both directions; received bits enter at the
	// end of each high phase.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shreg  <= 8'h00;
			rxbyte <= 8'h00;
			ack_rx <= 1'b0;
		end else if (state == ST_IDLE && tx_wr) begin
			shreg <= wb_dat_i[7:0];
		end else if (tick && !coll && step == 2'h1) begin
			if (state == ST_XMIT && last) begin
				ack_rx <= sda_s;
			end else if (state == ST_XMIT) begin
				shreg <= {shreg[6:0], 1'b0};
			end else if (state == ST_RECV) begin
				shreg <= {shreg[6:0], sda_s};
				if (last) begin
					rxbyte <= {shreg[6:0], sda_s};
				end
			end
		end
	end

	// Buffer-full flag drops when the byte is done or arbitration is lost.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			transmit_buffer_full <= 1'b0;
		end else if (coll || (done && state == ST_XMIT)) begin
			transmit_buffer_full <= 1'b0;
		end else if (state == ST_IDLE && tx_wr) begin
			transmit_buffer_full <= 1'b1;
		end
	end

	// Between events the master keeps the clock low; a stop or a lost
	// arbitration lets both lines go.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			park_low <= 1'b0;
		end else if (coll) begin
			park_low <= 1'b0;
		end else if (done) begin
			park_low <= (state != ST_STOP);
		end
	end

	// Line drivers are flops; a collision releases both at once.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			scl_oe <= want_scl && !coll;
			sda_oe <= want_sda && !coll;
		end
	end
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	// Clock-high tracking and data release age for the checks above.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			high_seen <= 1'b0;
			sda_age   <= 2'h0;
		end else begin
			if (scl_oe) begin
				high_seen <= 1'b0;
			end else if (scl_s) begin
				high_seen <= 1'b1;
			end
			if (sda_oe) begin
				sda_age <= 2'h0;
			end else if (sda_age != SDA_SETTLE) begin
				sda_age <= sda_age + 2'h1;
			end
		end
	end

	// Bus start and stop detection, whoever makes them.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_d      <= 1'b1;
			sda_d      <= 1'b1;
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			if (scl_s && scl_d && sda_d && !sda_s) begin
				start_seen <= 1'b1;
				stop_seen  <= 1'b0;
			end else if (scl_s && scl_d && !sda_d && sda_s) begin
				start_seen <= 1'b0;
				stop_seen  <= 1'b1;
			end
		end
	end

	// Collision flag: hardware set wins over a write-one clear.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			arbitration_lost_flag <= 1'b0;
		end else if (coll) begin
			arbitration_lost_flag <= 1'b1;
		end else if (wr && wb_adr_i == OFS_STAT && wm[STAT_BCL]
				&& wb_dat_i[STAT_BCL]) begin
			arbitration_lost_flag <= 1'b0;
		end
	end

	// Software settings: acknowledge level, baud reload, interrupt mask.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ackdt       <= 1'b0;
			baud_reload <= BAUD_RST;
			irq_mask    <= 2'h0;
		end else if (wr) begin
			if (wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
				ackdt <= wb_dat_i[CTRL_ACKDT];
			end
			if (wb_adr_i == OFS_BAUD) begin
				baud_reload <= (baud_reload & ~wm[BAUD_W-1:0])
					| (wb_dat_i[BAUD_W-1:0] & wm[BAUD_W-1:0]);
			end
			if (wb_adr_i == OFS_MASK) begin
				irq_mask <= (irq_mask & ~wm[1:0]) | (wb_dat_i[1:0] & wm[1:0]);
			end
		end
	end

	// Sticky event bits; an event in the clearing cycle survives.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_stat <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == IRQ_DONE && done) || (i == IRQ_COLL && coll)) begin
					irq_stat[i] <= 1'b1;
				end else if (wr && wb_adr_i == OFS_IRQ && wm[i] && wb_dat_i[i]) begin
					irq_stat[i] <= 1'b0;
				end
			end
		end
	end
	assign irq = |(irq_stat & irq_mask);

	// Read multiplexer; unmapped offsets read as zero.
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			OFS_CTRL: begin
				rdata[4:0]        = seq_bits(state);
				rdata[CTRL_ACKDT] = ackdt;
			end
			OFS_STAT: begin
				rdata[STAT_TRS]   = (state == ST_XMIT);
				rdata[STAT_BCL]   = arbitration_lost_flag;
				rdata[STAT_START] = start_seen;
				rdata[STAT_STOP]  = stop_seen;
				rdata[STAT_TBF]   = transmit_buffer_full;
				rdata[STAT_ACKRX] = ack_rx;
			end
			OFS_BAUD: rdata[BAUD_W-1:0] = baud_reload;
			OFS_RXD:  rdata[7:0]        = rxbyte;
			OFS_IRQ:  rdata[1:0]        = irq_stat;
			OFS_MASK: rdata[1:0]        = irq_mask;
			default:  rdata = 32'h0000_0000;
		endcase
	end

	// Classic single-cycle slave: acknowledge one cycle after the request.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= rdata;
			end
		end
	end

endmodule : imma_master
`default_nettype wire

// >>> core/imma_pkg.sv
package imma_pkg;

	// Register byte offsets on the bus.
	localparam int         ADR_W      = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STAT   = 8'h04;
	localparam logic [7:0] OFS_BAUD   = 8'h08;
	localparam logic [7:0] OFS_TXD    = 8'h0C;
	localparam logic [7:0] OFS_RXD    = 8'h10;
	localparam logic [7:0] OFS_IRQ    = 8'h14;
	localparam logic [7:0] OFS_MASK   = 8'h18;

	// Field positions in the control, status and interrupt words.
	localparam int         CTRL_ACKDT = 5;
	localparam int         STAT_TBF   = 0;
	localparam int         STAT_START = 3;
	localparam int         STAT_STOP  = 4;
	localparam int         STAT_BCL   = 10;
	localparam int         STAT_TRS   = 14;
	localparam int         STAT_ACKRX = 15;
	localparam int         IRQ_DONE   = 0;
	localparam int         IRQ_COLL   = 1;

	// One-hot sequence codes in the low five control bits.
	localparam logic [4:0] SEQ_START   = 5'h01;
	localparam logic [4:0] SEQ_RESTART = 5'h02;
	localparam logic [4:0] SEQ_STOP    = 5'h04;
	localparam logic [4:0] SEQ_RECV    = 5'h08;
	localparam logic [4:0] SEQ_ACK     = 5'h10;

	// Baud counter and bit counts.
	localparam int         BAUD_W     = 9;
	localparam logic [8:0] BAUD_RST   = 9'h027;
	localparam logic [8:0] BAUD_STEP  = 9'h002;
	localparam logic [3:0] XMIT_LAST  = 4'h8;
	localparam logic [3:0] RECV_LAST  = 4'h7;
	localparam logic [1:0] SDA_SETTLE = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_START   = 3'h1,
		ST_XMIT    = 3'h3,
		ST_RESTART = 3'h2,
		ST_RECV    = 3'h6,
		ST_ACK     = 3'h7,
		ST_STOP    = 3'h5
	} imma_state_t;

endpackage : imma_pkg

// >>> core/imma_sync.sv
`timescale 1ns/1ps
`default_nettype none
module imma_sync #(
	parameter int W = 2
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// Two stages; only the second stage is visible to other logic.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta <= '1;
			q    <= '1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : imma_sync
`default_nettype wire

// >>> dv/imma_master_bench.sv
`timescale 1ns/1ps
`default_nettype none
module imma_master_bench;
	import imma_pkg::*;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, irq, scl_o, sda_o, scl_oe, sda_oe;
	logic        scl_w, sda_w, scl_pull, sda_pull;
	logic        grab = 1'b0, cap = 1'b0;
	logic [3:0]  hold_len = 4'h0;
	logic [7:0]  txb;
	logic        bits[$];
	int          mismatches = 0;
	int          checked = 0;
	logic [4:0]  codes[4] = '{SEQ_RESTART, SEQ_RECV, SEQ_ACK, SEQ_STOP};
	logic [7:0]  ofs[8] = '{OFS_CTRL, OFS_STAT, OFS_BAUD, OFS_IRQ,
		OFS_MASK, 8'h1C, OFS_TXD, OFS_RXD};
	logic [31:0] rstv[8] = '{32'h0, 32'h0, {23'h0, BAUD_RST}, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h0};
	// Open-drain wires with pull-ups.
	assign scl_w = !(scl_oe | scl_pull);
	assign sda_w = !(sda_oe | sda_pull);
	always #10 clock = ~clock;
	// The far end takes a bit on each rising clock wire.
	always @(posedge scl_w) begin
		if (cap) bits.push_back(sda_w);
	end
	imma_master u_imma_master (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
		.scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_o(sda_o), .sda_oe(sda_oe));
	imma_peer u_imma_peer (.clock(clock), .rst(rst), .scl_w(scl_w),
		.grab(grab), .hold_len(hold_len), .scl_pull(scl_pull),
		.sda_pull(sda_pull));
	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One classic cycle; request held until ack is sampled high.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		check("ack", {31'h0, ack}, 32'h1);
		cyc <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rchk(input string what, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		check(what, x & m, e);
	endtask : rchk
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		check("irq", {31'h0, irq}, 32'h1);
	endtask : wait_irq
	// Launch one sequence and wait for its event; clear it only when it is the done event.
	task automatic step(input logic [4:0] c, input logic [31:0] ev);
		wr(OFS_CTRL, {27'h0, c});
		if (ev == 32'h1) rchk("ctrl", OFS_CTRL, 32'h1F, {27'h0, c});
		wait_irq();
		rchk("event", OFS_IRQ, 32'h3, ev);
		rchk("ctrl end", OFS_CTRL, 32'h1F, 32'h0);
		if (ev == 32'h1) wr(OFS_IRQ, 32'h3);
	endtask : step
	// A hang is cut short well beyond the expected run length.
	initial begin
		#1000000;
		mismatches++;
		final_report();
	end
	initial begin
		void'($urandom(32'h98286105));
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		foreach (ofs[i]) rchk("reset", ofs[i], 32'hFFFFFFFF, rstv[i]);
		wr(OFS_BAUD, 32'h4);
		wr(OFS_MASK, 32'h3);
		rchk("idle", OFS_STAT, 32'h18, 32'h0);
		step(SEQ_START, 32'h1);
		rchk("flags", OFS_STAT, 32'h18, 32'h8);
		// A random byte while the peer stretches each low phase.
		txb = 8'($urandom);
		hold_len <= 4'($urandom_range(8, 1));
		cap = 1'b1;
		wr(OFS_TXD, {24'h0, txb});
		rchk("busy", OFS_STAT, 32'h4000, 32'h4000);
		wr(OFS_CTRL, {27'h0, SEQ_STOP});
		rchk("no queue", OFS_CTRL, 32'h1F, 32'h0);
		wait_irq();
		cap = 1'b0;
		for (int i = 0; i < 8; i++) begin
			check("bit", {31'h0, bits[i]}, {31'h0, txb[7-i]});
		end
		wr(OFS_IRQ, 32'h3);
		foreach (codes[i]) begin
			hold_len <= 4'($urandom_range(8, 0));
			step(codes[i], 32'h1);
		end
		rchk("rx", OFS_RXD, 32'hFF, 32'hFF);
		rchk("flags", OFS_STAT, 32'h18, 32'h10);
		// Another master holds data low: the start is lost.
		hold_len <= 4'h0;
		grab <= 1'b1;
		step(SEQ_START, 32'h2);
		check("free", {30'h0, scl_oe, sda_oe}, 32'h0);
		rchk("lost", OFS_STAT, 32'h400, 32'h400);
		wr(OFS_MASK, 32'h1);
		check("masked", {31'h0, irq}, 32'h0);
		wr(OFS_MASK, 32'h0);
		check("none", {31'h0, irq}, 32'h0);
		wr(OFS_MASK, 32'h3);
		check("unmasked", {31'h0, irq}, 32'h1);
		wr(OFS_STAT, 32'h400);
		wr(OFS_IRQ, 32'h3);
		check("cleared", {31'h0, irq}, 32'h0);
		rchk("lost clr", OFS_STAT, 32'h400, 32'h0);
		grab <= 1'b0;
		// The released data line needs the synchroniser and the edge
		// detector behind it before the stop flag can show.
		repeat (4) @(posedge clock);
		rchk("idle", OFS_STAT, 32'h18, 32'h10);
		step(SEQ_START, 32'h1);
		// A loss on the first bit of a byte halts the transfer.
		grab <= 1'b1;
		wr(OFS_TXD, 32'hFF);
		wait_irq();
		rchk("event", OFS_IRQ, 32'h3, 32'h2);
		rchk("halted", OFS_STAT, 32'h4401, 32'h400);
		check("free", {30'h0, scl_oe, sda_oe}, 32'h0);
		// A restart against a talker holding data low is lost.
		wr(OFS_IRQ, 32'h3);
		step(SEQ_RESTART, 32'h2);
		check("released", {30'h0, scl_oe, sda_oe}, 32'h0);
		check("levels", {30'h0, scl_o, sda_o}, 32'h0);
		grab <= 1'b0;
		final_report();
	end
endmodule : imma_master_bench
`default_nettype wire

// >>> dv/imma_master_chk.sv
`timescale 1ns/1ps
`default_nettype none
module imma_master_chk (
	input wire logic                       clock,
	input wire logic                       rst,
	input wire logic                       wb_cyc_i,
	input wire logic                       wb_stb_i,
	input wire logic                       wb_we_i,
	input wire logic [imma_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]                 wb_sel_i,
	input wire logic [31:0]                wb_dat_i,
	input wire logic [31:0]                wb_dat_o,
	input wire logic                       wb_ack_o,
	input wire logic                       irq,
	input wire logic                       scl_i,
	input wire logic                       sda_i,
	input wire logic                       scl_o,
	input wire logic                       scl_oe,
	input wire logic                       sda_o,
	input wire logic                       sda_oe
);
	import imma_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	logic take;
	logic wrote;
	// A request is taken where strobe is up and no ack stands.
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// The wires must stay untouched until software has written something.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wrote <= 1'b0;
		end else if (take && wb_we_i) begin
			wrote <= 1'b1;
		end
	end
	a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack high two cycles");
	a_ack_next_edge: assert property (take |=> wb_ack_o)
		else $error("request not answered");
	a_reset_lines_idle: assert property ($fell(rst) |->
		!wb_ack_o && !irq && !scl_oe && !sda_oe)
		else $error("outputs busy after reset");
	a_quiet_before_use: assert property (!wrote |-> !scl_oe && !sda_oe)
		else $error("wire driven before any command");
	a_clock_wait_low:
		assert property (!scl_oe && !scl_i |=> !scl_oe)
		else $error("clock pulled while held low");
	a_clock_high_min:
		assert property ($rose(scl_i) && !scl_oe |=> !scl_oe [*2])
		else $error("clock high phase too short");
	a_unmapped_zero:
		assert property (take && !wb_we_i && wb_adr_i == 8'h1C
		|=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_txd_reads_zero:
		assert property (take && !wb_we_i && wb_adr_i == OFS_TXD
		|=> wb_dat_o == 32'h0)
		else $error("transmit data read not zero");
	a_mask_gates_irq:
		assert property (take && wb_we_i && wb_adr_i == OFS_MASK
		&& wb_sel_i[0] && wb_dat_i[1:0] == 2'h0 |=> !irq)
		else $error("irq high with all masked");
	c_irq_raised: cover property ($rose(irq));
	c_clock_stretched: cover property ((!scl_oe && !scl_i) [*3]);
	c_data_lost: cover property (!sda_oe && !sda_i && scl_i);
endmodule : imma_master_chk
bind imma_master imma_master_chk u_imma_master_chk (.clock(clock),
	.rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq(irq), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o),
	.scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// >>> dv/imma_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Another party on the wires: stretches the clock, may hold data low.
module imma_peer (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       scl_w,
	input  wire logic       grab,
	input  wire logic [3:0] hold_len,
	output logic            scl_pull,
	output logic            sda_pull
);
	logic       scl_d;
	logic [3:0] left;
	// A falling clock wire is held low for hold_len more cycles.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_d <= 1'b1;
			left <= 4'h0;
		end else begin
			scl_d <= scl_w;
			if (scl_d && !scl_w) begin
				left <= hold_len;
			end else if (left != 4'h0) begin
				left <= left - 4'h1;
			end
		end
	end
	assign scl_pull = (left != 4'h0);
	// A winning talker drives zero; when released the pull-up wins.
	assign sda_pull = grab;
endmodule : imma_peer
`default_nettype wire
